// ---- rtl/rfpm_pkg.sv ----
// shared constants for the rf port multiplexer control block
package rfpm_pkg;
  // serial frame layout: read/write flag, 7 address bits, 8 data bits
  localparam int FRAME_BITS = 16;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam logic [4:0] HDR_DONE = 5'h08;
  localparam logic [4:0] FRAME_DONE = 5'h10;

  // register byte addresses
  localparam logic [6:0] ADDR_PORT_SWITCH = 7'h01;
  localparam logic [6:0] ADDR_RXTX = 7'h04;

  // port switch register fields
  localparam int PORT_SEL_LSB = 0;
  localparam int DETACH_BIT = 2;
  localparam logic [1:0] PORT_SEL_RESET = 2'h0;
  localparam logic DETACH_RESET = 1'b0;

  // receive / transmit level register fields
  localparam int RX_CODE_LSB = 0;
  localparam int TX_CODE_LSB = 4;
  localparam logic [3:0] RX_CODE_RESET = 4'hB;
  localparam logic [3:0] TX_CODE_RESET = 4'h7;

  // timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int BREAK_NS = 100;
  localparam int BREAK_CYCLES =
    (BREAK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [1:0] CARRIER_DIV_LAST = 2'h3;

  typedef enum logic [1:0] {
    RFPM_SW_IDLE  = 2'b00,
    RFPM_SW_BREAK = 2'b01,
    RFPM_SW_MAKE  = 2'b10
  } rfpm_sw_state_e;
endpackage

// ---- rtl/rfpm_port_switch.sv ----
// break-before-make sequencer for the four rf ports
`timescale 1ns/10ps
module rfpm_port_switch #(
  parameter int BREAK_CYCLES = rfpm_pkg::BREAK_CYCLES
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // request from the serial side
  input wire logic i_req_toggle,
  input wire logic [1:0] i_req_port,
  // switch drive
  output logic [3:0] o_port_connect,
  output logic [3:0] o_port_term
);
  localparam int CNT_W = $clog2(BREAK_CYCLES + 1);
  localparam logic [CNT_W-1:0] BREAK_LAST = CNT_W'(BREAK_CYCLES - 1);

  logic req_meta;
  logic req_sync;
  logic req_seen;
  logic [1:0] port_hold;
  logic [3:0] connect;
  logic [CNT_W-1:0] cnt;
  rfpm_pkg::rfpm_sw_state_e state;
  rfpm_pkg::rfpm_sw_state_e next_state;

  wire req_event = req_sync ^ req_seen;
  wire break_done = (cnt == BREAK_LAST);
  wire [3:0] onehot = 4'h1 << port_hold;

  // toggle crossing: first stage is read only by the second
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
      req_seen <= 1'b0;
    end else begin
      req_meta <= i_req_toggle;
      req_sync <= req_meta;
      req_seen <= req_sync;
    end
  end

  always_comb begin
    next_state = state;
    case (state)
      rfpm_pkg::RFPM_SW_IDLE: begin
        if (req_event) begin
          next_state = rfpm_pkg::RFPM_SW_BREAK;
        end
      end
      rfpm_pkg::RFPM_SW_BREAK: begin
        if (req_event) begin
          next_state = rfpm_pkg::RFPM_SW_BREAK;
        end else if (break_done) begin
          next_state = rfpm_pkg::RFPM_SW_MAKE;
        end
      end
      rfpm_pkg::RFPM_SW_MAKE: begin
        if (req_event) begin
          next_state = rfpm_pkg::RFPM_SW_BREAK;
        end else begin
          next_state = rfpm_pkg::RFPM_SW_IDLE;
        end
      end
      default: begin
        next_state = rfpm_pkg::RFPM_SW_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state <= rfpm_pkg::RFPM_SW_MAKE;
      port_hold <= rfpm_pkg::PORT_SEL_RESET;
      cnt <= '0;
      connect <= 4'h0;
    end else begin
      state <= next_state;
      if (req_event) begin
        port_hold <= i_req_port;
        connect <= 4'h0;
        cnt <= '0;
      end else if (state == rfpm_pkg::RFPM_SW_BREAK && !break_done) begin
        cnt <= cnt + CNT_W'(1);
      end else if (state == rfpm_pkg::RFPM_SW_MAKE) begin
        connect <= onehot;
      end
    end
  end

  assign o_port_connect = connect;
  assign o_port_term = ~connect;
endmodule

// ---- rtl/rfpm_top.sv ----
// serial register file, receiver decision and port control of the rf mux
// Behaviour
// - port select code 0 to 3 joins port zero to port three to the node.
// - register 0x01 holds port select and detach bit; detach 0 attaches.
// - either all ports are terminated or exactly one port is connected.
// - on a change the old port is terminated before the new one connects.
// - every port not joined to the node is switched to its termination.
// - a change starts only at the sixteenth rising clock of a whole frame.
// - a written selection crosses a synchroniser before it takes effect.
// - the receive threshold code resets to 0xB, meaning -15dBm.
// - each lower threshold code lowers the threshold by about half a dB.
// - carrier at or above threshold drives direction high and data low.
// - the keyed carrier on the selected port becomes the receive data.
// - the timebase runs from a crystal or a shared external clock.
// - the transmit level code sets the output power at the port.
// - direction is high while carrier is detected on the port, the inverse of data.
`timescale 1ns/10ps
module rfpm_top #(
  parameter int BREAK_CYCLES = rfpm_pkg::BREAK_CYCLES
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // serial register port
  input wire logic i_sclk,
  input wire logic i_chip_select_n,
  input wire logic i_sdi,
  output logic o_sdo,
  // receive path
  input wire logic [3:0] i_rx_env,
  input wire logic [3:0] i_rx_level,
  output logic o_rx_bit_out,
  output logic o_dir,
  output logic [3:0] o_rx_threshold_code,
  // transmit path
  input wire logic i_tx_bit_in,
  output logic o_tx_carrier,
  output logic [3:0] o_tx_level_code,
  // rf port switches
  output logic [3:0] o_port_connect,
  output logic [3:0] o_port_term,
  output logic o_modem_attached,
  // oscillator
  input wire logic i_osc_input_a,
  input wire logic i_osc_input_b,
  output logic o_osc_external,
  output logic o_timebase_share_out,
  output logic o_timebase_share_oe
);
  logic sclk_q;
  logic [4:0] bit_cnt;
  logic [15:0] shift_in;
  logic [7:0] rd_shift;
  logic sdo;
  logic [1:0] port_sel;
  logic detach;
  logic [3:0] rx_code;
  logic [3:0] tx_code;
  logic req_toggle;
  logic [1:0] div_cnt;
  logic carrier_phase;
  logic rx_on;
  logic osc_ext;

  // address match shared by the write strobes and the read mux
  function automatic logic addr_match(input logic [6:0] addr,
    input logic [6:0] reg_addr);
    addr_match = (addr == reg_addr);
  endfunction

  // serial frame decode
  wire sclk_rise = i_sclk & ~sclk_q;
  wire sclk_fall = ~i_sclk & sclk_q;
  wire active = ~i_chip_select_n;
  wire [15:0] frame = {shift_in[14:0], i_sdi};
  wire hdr_edge = active & sclk_rise & (bit_cnt == rfpm_pkg::HDR_DONE - 5'h1);
  wire last_edge =
    active & sclk_rise & (bit_cnt == rfpm_pkg::FRAME_DONE - 5'h1);
  wire wr_flag = ~frame[15];
  wire [6:0] wr_addr = frame[14:8];
  wire [7:0] wr_data = frame[7:0];
  wire [6:0] hdr_addr = frame[6:0];
  wire wr_port = last_edge & wr_flag &
    addr_match(wr_addr, rfpm_pkg::ADDR_PORT_SWITCH);
  wire wr_rxtx = last_edge & wr_flag &
    addr_match(wr_addr, rfpm_pkg::ADDR_RXTX);
  wire [7:0] port_reg = {5'h00, detach, port_sel};
  wire [7:0] rxtx_reg = {tx_code, rx_code};
  wire [7:0] rd_data =
    addr_match(hdr_addr, rfpm_pkg::ADDR_PORT_SWITCH) ? port_reg :
    addr_match(hdr_addr, rfpm_pkg::ADDR_RXTX) ? rxtx_reg : 8'h00;

  // serial clock history for edge detection
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= i_sclk;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      bit_cnt <= 5'h00;
      shift_in <= 16'h0000;
    end else begin
      if (!active) begin
        bit_cnt <= 5'h00;
      end else if (sclk_rise) begin
        shift_in <= frame;
        if (bit_cnt != rfpm_pkg::FRAME_DONE) begin
          bit_cnt <= bit_cnt + 5'h01;
        end
      end
    end
  end

  // read data leave msb first on falling clocks after the header
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      rd_shift <= 8'h00;
      sdo <= 1'b0;
    end else if (!active) begin
      sdo <= 1'b0;
    end else if (hdr_edge) begin
      rd_shift <= frame[7] ? rd_data : 8'h00;
    end else if (sclk_fall && bit_cnt >= rfpm_pkg::HDR_DONE &&
                 bit_cnt != rfpm_pkg::FRAME_DONE) begin
      sdo <= rd_shift[7];
      rd_shift <= {rd_shift[6:0], 1'b0};
    end
  end

  // port switch register and the request toggle toward the switch
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      port_sel <= rfpm_pkg::PORT_SEL_RESET;
      detach <= rfpm_pkg::DETACH_RESET;
      req_toggle <= 1'b0;
    end else if (wr_port) begin
      port_sel <= wr_data[rfpm_pkg::PORT_SEL_LSB +: 2];
      detach <= wr_data[rfpm_pkg::DETACH_BIT];
      req_toggle <= ~req_toggle;
    end
  end

  // receive threshold and transmit level register
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      rx_code <= rfpm_pkg::RX_CODE_RESET;
      tx_code <= rfpm_pkg::TX_CODE_RESET;
    end else if (wr_rxtx) begin
      rx_code <= wr_data[rfpm_pkg::RX_CODE_LSB +: 4];
      tx_code <= wr_data[rfpm_pkg::TX_CODE_LSB +: 4];
    end
  end

  rfpm_port_switch #(
    .BREAK_CYCLES(BREAK_CYCLES)
  ) rfpm_port_switch_i (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_req_toggle(req_toggle),
    .i_req_port(port_sel),
    .o_port_connect(o_port_connect),
    .o_port_term(o_port_term)
  );

  // carrier timebase: one sample enable every fourth clock
  wire carrier_tick = (div_cnt == rfpm_pkg::CARRIER_DIV_LAST);
  wire port_env = |(i_rx_env & o_port_connect);
  wire above = port_env & (i_rx_level >= rx_code);
  wire next_rx_on = above & ~detach;

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      div_cnt <= 2'h0;
    end else begin
      div_cnt <= div_cnt + 2'h1;
    end
  end

  // transmit carrier phase, flipped on every sample enable
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      carrier_phase <= 1'b0;
    end else if (carrier_tick) begin
      carrier_phase <= ~carrier_phase;
    end
  end

  // receive decision, taken once per sample enable
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      rx_on <= 1'b0;
    end else if (carrier_tick) begin
      rx_on <= next_rx_on;
    end
  end

  // external timebase detect: a driven while b held low
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      osc_ext <= 1'b0;
    end else begin
      osc_ext <= i_osc_input_a & ~i_osc_input_b;
    end
  end

  assign o_sdo = sdo;
  assign o_dir = rx_on;
  assign o_rx_bit_out = ~rx_on;
  assign o_rx_threshold_code = rx_code;
  assign o_tx_level_code = tx_code;
  assign o_tx_carrier = carrier_phase & ~i_tx_bit_in & ~detach;
  assign o_modem_attached = ~detach;
  assign o_osc_external = osc_ext;
  assign o_timebase_share_out = 1'b0;
  assign o_timebase_share_oe = ~carrier_phase;
endmodule

// ---- tb/rfpm_asserts.sv ----
// port-level assertions for the rf port mux control block
`timescale 1ns/10ps
module rfpm_asserts (
  // watched ports
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire logic [3:0] i_rx_env,
  input wire logic [3:0] i_rx_level,
  input wire logic i_tx_bit_in,
  input wire logic o_rx_bit_out,
  input wire logic o_dir,
  input wire logic [3:0] o_rx_threshold_code,
  input wire logic o_tx_carrier,
  input wire logic [3:0] o_port_connect,
  input wire logic [3:0] o_port_term,
  input wire logic o_modem_attached
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  wire logic hit = |(i_rx_env & o_port_connect) & o_modem_attached &
    (i_rx_level >= o_rx_threshold_code);
  AST_ONE_PORT: assert property ($onehot0(o_port_connect))
    else $error("more than one port joined");
  AST_TERM: assert property (o_port_term == ~o_port_connect)
    else $error("free port not terminated");
  AST_BREAK: assert property (o_port_connect != 4'h0 &&
    $changed(o_port_connect) |-> $past(o_port_connect) == 4'h0)
    else $error("port made without break");
  AST_DIR_PAIR: assert property (o_dir != o_rx_bit_out)
    else $error("direction and data disagree");
  AST_DIR_CAUSE: assert property ($rose(o_dir) |-> $past(hit))
    else $error("direction rose without carrier");
  AST_DETACH: assert property ((!o_modem_attached) [*5] |-> !o_dir)
    else $error("direction high while detached");
  AST_DIV4: assert property ($changed(o_dir) |=> $stable(o_dir) [*3])
    else $error("receive decision faster than four clocks");
  AST_TX_GATE: assert property (o_tx_carrier |->
    !i_tx_bit_in && o_modem_attached)
    else $error("carrier without key");
  AST_RX_RESET: assert property ($fell(i_reset) |->
    o_rx_threshold_code == 4'hB)
    else $error("threshold code reset value");
  cover property ($rose(o_dir));
  cover property (o_port_connect == 4'h8);
  cover property (!o_modem_attached);
endmodule
bind rfpm_top rfpm_asserts rfpm_asserts_i (.i_mclk(i_mclk),
  .i_reset(i_reset), .i_rx_env(i_rx_env), .i_rx_level(i_rx_level),
  .i_tx_bit_in(i_tx_bit_in), .o_rx_bit_out(o_rx_bit_out), .o_dir(o_dir),
  .o_rx_threshold_code(o_rx_threshold_code), .o_tx_carrier(o_tx_carrier),
  .o_port_connect(o_port_connect), .o_port_term(o_port_term),
  .o_modem_attached(o_modem_attached));

// ---- tb/rfpm_feeder.sv ----
// feeder side model: keyed carrier per port and oscillator pins
`timescale 1ns/10ps
module rfpm_feeder (
  // carrier per port, one level code for all ports, timebase choice
  input wire logic [3:0] i_key,
  input wire logic [3:0] i_pwr,
  input wire logic i_ext,
  // toward the block
  output logic [3:0] o_env,
  output logic [3:0] o_level,
  output logic o_osc_a,
  output logic o_osc_b
);
  assign o_env = i_key;
  assign o_level = i_pwr;
  assign o_osc_a = i_ext;
  assign o_osc_b = ~i_ext;
endmodule

// ---- tb/rfpm_top_tb.sv ----
// self-checking bench for the rf port mux control block
`timescale 1ns/10ps
module rfpm_top_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic sclk = 1'b0;
  logic cs_n = 1'b1;
  logic sdi = 1'b0;
  logic tx = 1'b1;
  logic ext = 1'b0;
  logic [3:0] key = 4'h0;
  logic [3:0] pwr = 4'h0;
  logic [3:0] env, lvl, conn, term, rxc, txc;
  logic sdo, rxo, dir, txo, att, osca, oscb, osce, sho, shoe;
  logic [7:0] q;
  int failures = 0;
  int total_checks = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  rfpm_top #(.BREAK_CYCLES(2)) rfpm_top_i (.i_mclk(clk), .i_reset(rst),
    .i_sclk(sclk), .i_chip_select_n(cs_n), .i_sdi(sdi), .o_sdo(sdo),
    .i_rx_env(env), .i_rx_level(lvl), .o_rx_bit_out(rxo), .o_dir(dir),
    .o_rx_threshold_code(rxc), .i_tx_bit_in(tx), .o_tx_carrier(txo),
    .o_tx_level_code(txc), .o_port_connect(conn), .o_port_term(term),
    .o_modem_attached(att), .i_osc_input_a(osca), .i_osc_input_b(oscb),
    .o_osc_external(osce), .o_timebase_share_out(sho),
    .o_timebase_share_oe(shoe));
  rfpm_feeder rfpm_feeder_i (.i_key(key), .i_pwr(pwr), .i_ext(ext),
    .o_env(env), .o_level(lvl), .o_osc_a(osca), .o_osc_b(oscb));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wrap_up;
    $display("failures=%0d total_checks=%0d", failures, total_checks);
    if (failures == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task spi(input logic rw, input logic [6:0] a, input logic [7:0] d,
    input int n);
    logic [15:0] f;
    f = {rw, a, d};
    cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      sdi = f[15-i];
      sclk = 1'b0;
      tick(2);
      if (i > 7) q[15-i] = sdo;
      sclk = 1'b1;
      tick(2);
    end
    sclk = 1'b0;
    tick(2);
    cs_n = 1'b1;
    tick(2);
  endtask
  task wait_conn(input logic [3:0] e);
    for (int k = 0; k < 60 && conn !== e; k++) tick(1);
    chk({4'h0, conn}, {4'h0, e});
    chk({4'h0, term}, {4'h0, ~e});
  endtask
  task rx_case(input logic [3:0] k, input logic [3:0] p, input logic e);
    key = k;
    pwr = p;
    tick(8);
    chk({6'h0, dir, rxo}, e ? 8'h02 : 8'h01);
  endtask
  task t_reset;
    spi(1'b1, 7'h04, 8'h00, 16);
    chk(q, 8'h7B);
    spi(1'b1, 7'h01, 8'h00, 16);
    chk(q, 8'h00);
    chk({7'h0, att}, 8'h01);
    wait_conn(4'h1);
    spi(1'b1, 7'h02, 8'h00, 16);
    chk(q, 8'h00);
  endtask
  task t_ports;
    for (int p = 0; p < 4; p++) begin
      spi(1'b0, 7'h01, 8'(p), 16);
      wait_conn(4'h1 << p);
    end
    spi(1'b0, 7'h01, 8'h01, 12);
    tick(40);
    chk({4'h0, conn}, 8'h08);
  endtask
  task t_rx;
    rx_case(4'h8, 4'hB, 1'b1);
    rx_case(4'h8, 4'hA, 1'b0);
    rx_case(4'h2, 4'hF, 1'b0);
    spi(1'b0, 7'h04, 8'h70, 16);
    chk({4'h0, rxc}, 8'h00);
    rx_case(4'h8, 4'h0, 1'b1);
    rx_case(4'h0, 4'hF, 1'b0);
  endtask
  task t_detach;
    spi(1'b0, 7'h01, 8'h07, 16);
    spi(1'b1, 7'h01, 8'h00, 16);
    chk(q, 8'h07);
    chk({7'h0, att}, 8'h00);
    tx = 1'b0;
    rx_case(4'h8, 4'hF, 1'b0);
    tx = 1'b1;
    spi(1'b0, 7'h01, 8'h03, 16);
    chk({7'h0, att}, 8'h01);
  endtask
  task t_tx;
    int n;
    int m;
    spi(1'b0, 7'h04, 8'hD0, 16);
    chk({4'h0, txc}, 8'h0D);
    n = 0;
    m = 0;
    tx = 1'b0;
    repeat (16) begin
      tick(1);
      n += int'(txo === 1'b1);
      m += int'(shoe === 1'b1);
      chk({7'h0, sho}, 8'h00);
    end
    tx = 1'b1;
    chk(8'(n), 8'h08);
    chk(8'(m), 8'h08);
    ext = 1'b1;
    tick(3);
    chk({7'h0, osce}, 8'h01);
    ext = 1'b0;
    tick(3);
    chk({7'h0, osce}, 8'h00);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      failures++;
      wrap_up;
    end
  end
  initial begin
    tick(10);
    rst = 1'b0;
    tick(2);
    t_reset;
    t_ports;
    t_rx;
    t_detach;
    t_tx;
    wrap_up;
  end
endmodule
